// ---- bench/pdma_pcm_peer.sv ----
// Far-end PCM line model sending a byte made from the slot number in every slot
`timescale 1ns/1ps
module pdma_pcm_peer #(
   parameter int REF_DIV = 12
) (
   // Clock
   input  wire logic aclk,
   // Line
   input  wire logic pcm_frame_sync,
   output logic      pcm_rx_in
);
   logic [15:0] cnt_r    = 16'h0;
   logic        sync_q_r = 1'b0;
   logic [9:0]  pos;
   logic [7:0]  slot_byte;
   // Bit leads the sampling tick so the input synchroniser delay is covered
   assign pos       = 10'((int'(cnt_r) + REF_DIV / 2 + 2) / REF_DIV);
   assign slot_byte = {pos[6:3], ~pos[6:3]};
   always @(posedge aclk) begin
      sync_q_r  <= pcm_frame_sync;
      cnt_r     <= (pcm_frame_sync && !sync_q_r) ? 16'h1 : cnt_r + 16'h1;
      pcm_rx_in <= slot_byte[3'h7 - pos[2:0]];
   end
endmodule : pdma_pcm_peer

// ---- bench/pdma_props.sv ----
// Port checker for the PCM data memory access block
`timescale 1ns/1ps
module pdma_props (
   // Clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // Write channels
   input wire logic [5:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   // Read channels
   input wire logic [5:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // PCM port
   input wire logic        pcm_tx_oe,
   input wire logic        pcm_drive_enable_line_n
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   wire logic wr_hs  = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   wire logic ar_hs  = s_axi_arvalid && s_axi_arready;
   wire logic aw_map = (s_axi_awaddr[5:2] <= pdma_pkg::OFS_STATUS[5:2]);
   wire logic ar_map = (s_axi_araddr[5:2] <= pdma_pkg::OFS_STATUS[5:2]);
   wr_resp_time_a: assert property (wr_hs |-> ##2 s_axi_bvalid)
      else $error("write response not two cycles after take");
   wr_held_off_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write channel ready during response");
   wr_okay_a: assert property (wr_hs && aw_map |-> ##2 s_axi_bresp == pdma_pkg::RESP_OKAY)
      else $error("mapped write not answered okay");
   wr_slverr_a: assert property (wr_hs && !aw_map |-> ##2 s_axi_bresp == pdma_pkg::RESP_SLVERR)
      else $error("unmapped write not answered with error");
   rd_resp_a: assert property (ar_hs |=> s_axi_rvalid && !s_axi_arready)
      else $error("read data not one cycle after take");
   rd_slverr_a: assert property (ar_hs && !ar_map |=>
      s_axi_rresp == pdma_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not answered with error and zero");
   rd_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
      else $error("read channel not freed after handshake");
   rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("upper read data bits not zero");
   status_bits_a: assert property (ar_hs && s_axi_araddr == pdma_pkg::OFS_STATUS |=>
      s_axi_rdata[31:1] == 31'h0) else $error("status read has stray bits");
   drive_pair_a: assert property (pcm_drive_enable_line_n == !pcm_tx_oe)
      else $error("drive enable line disagrees with output enable");
endmodule : pdma_props

bind pdma_top pdma_props u_props (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
   .s_axi_rready, .pcm_tx_oe, .pcm_drive_enable_line_n);

// ---- bench/pdma_top_tb_top.sv ----
// Self-checking bench for the PCM data memory access block
`timescale 1ns/1ps
module pdma_top_tb_top;
   localparam int DIV = 12;
   logic        aclk = 1'b0, aresetn = 1'b0, fs_q = 1'b0;
   logic [5:0]  s_axi_awaddr, s_axi_araddr;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd_v;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, resp_v;
   logic        pcm_rx_in, pcm_tx_out, pcm_tx_oe, pcm_drive_enable_line_n, pcm_frame_sync;
   logic [7:0]  ex, dv;
   int          fc = 0, cyc = 0, t0, el, num_errors = 0, tests_run = 0;
   logic [3:0]  op_t [8] = '{4'h1, 4'h3, 4'h2, 4'h7, 4'h6, 4'h5, 4'h4, 4'h0};
   logic [7:0]  msk_t [8] = '{8'hFF, 8'hF0, 8'h0F, 8'hC0, 8'h30, 8'h0C, 8'h03, 8'h00};

   pdma_top #(.SLOT_AW(7), .REF_DIV(DIV)) DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pcm_rx_in, .pcm_tx_out,
      .pcm_tx_oe, .pcm_drive_enable_line_n, .pcm_frame_sync);
   pdma_pcm_peer #(.REF_DIV(DIV)) u_peer (.aclk, .pcm_frame_sync, .pcm_rx_in);

   always #2 aclk = ~aclk;
   always @(posedge aclk) begin
      fs_q <= pcm_frame_sync;
      fc   <= (pcm_frame_sync && !fs_q) ? 1 : fc + 1;
      cyc  <= cyc + 1;
   end
   // ---------------------------------------------------------------
   // Bus, PCM line and check tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      resp_v = s_axi_bresp;
   endtask : wr
   task automatic rd(input logic [5:0] a);
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      rd_v   = s_axi_rdata;
      resp_v = s_axi_rresp;
   endtask : rd
   task automatic op(input logic [7:0] a, input logic [7:0] d, input logic [7:0] c);
      int n;
      wr(pdma_pkg::OFS_DATA, d);
      wr(pdma_pkg::OFS_ADDRESS, a);
      t0 = cyc;
      wr(pdma_pkg::OFS_COMMAND, c);
      rd(pdma_pkg::OFS_STATUS);
      chk(rd_v, 32'h1, "busy flag");
      n = 0;
      while (rd_v[0] && n < 6000) begin
         rd(pdma_pkg::OFS_STATUS);
         n++;
      end
      el = cyc - t0;
      chk(rd_v, 32'h0, "busy cleared");
   endtask : op
   task automatic check_slot(input int s, input logic [7:0] v, input logic [3:0] t);
      for (int b = 7; b >= 0; b--) begin
         do @(negedge aclk); while (fc != (s * 8 + 7 - b) * DIV + DIV / 2);
         chk(32'(pcm_tx_oe), 32'(t[b / 2]), "output enable");
         chk(32'(pcm_drive_enable_line_n), 32'(!t[b / 2]), "enable line");
         if (t[b / 2]) chk(32'(pcm_tx_out), 32'(v[b]), "tx bit");
      end
   endtask : check_slot
   task report_and_stop;
      $display("checks %0d errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : report_and_stop
   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         rd(6'(4 * i));
         chk(rd_v, 32'h0, "reset value");
      end
      wr(6'h10, 8'h55);
      chk(32'(resp_v), 32'(pdma_pkg::RESP_SLVERR), "unmapped write");
      rd(6'h14);
      chk(32'(resp_v), 32'(pdma_pkg::RESP_SLVERR), "unmapped read");
      ex = 8'h00;
      for (int i = 0; i < 8; i++) begin
         dv = 8'(8'h17 * (i + 1));
         ex = (ex & ~msk_t[i]) | (dv & msk_t[i]);
         op(8'h06, dv, {1'b0, op_t[i], 3'h0});
         if (i == 0) chk(32'(el <= 10 * DIV + 16), 32'h1, "access time");
         op(8'h86, 8'h00, 8'h80);
         rd(pdma_pkg::OFS_DATA);
         chk(rd_v, 32'(ex), "upstream byte");
      end
      // Undefined codes leave memory and data register alone
      op(8'h06, 8'h3C, 8'h40);
      op(8'h86, 8'h3C, 8'hC8);
      rd(pdma_pkg::OFS_DATA);
      chk(rd_v, 32'h3C, "unused read code");
      op(8'h86, 8'h00, 8'h80);
      rd(pdma_pkg::OFS_DATA);
      chk(rd_v, 32'(ex), "unused write code");
      op(8'h85, 8'hA5, 8'h08);
      op(8'h05, 8'hFF, 8'h60);
      op(8'h06, 8'hF3, 8'h60);
      op(8'h86, 8'h00, 8'hE0);
      rd(pdma_pkg::OFS_DATA);
      chk(rd_v, 32'h03, "tristate readback");
      repeat (2) begin
         check_slot(5, 8'hA5, 4'hF);
         check_slot(6, ex, 4'h3);
      end
      op(8'h05, 8'h00, 8'h80);
      rd(pdma_pkg::OFS_DATA);
      chk(rd_v, 32'h5A, "received byte");
      op(8'h06, 8'h00, 8'h80);
      rd(pdma_pkg::OFS_DATA);
      chk(rd_v, 32'h69, "downstream untouched");
      op(8'h33, 8'hF0, 8'h68);
      chk(32'(el <= pdma_pkg::FILL_REF_MAX * DIV), 32'h1, "fill time");
      op(8'h85, 8'h00, 8'hE0);
      rd(pdma_pkg::OFS_DATA);
      chk(rd_v, 32'h0, "filled code");
      check_slot(5, 8'hA5, 4'h0);
      report_and_stop;
   end
   initial begin
      repeat (90000) @(posedge aclk);
      num_errors++;
      report_and_stop;
   end
endmodule : pdma_top_tb_top

// ---- verilog/pdma_pkg.sv ----
// Constants for the PCM data memory access block
package pdma_pkg;
   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [5:0] OFS_DATA    = 6'h00;
   localparam logic [5:0] OFS_ADDRESS = 6'h04;
   localparam logic [5:0] OFS_COMMAND = 6'h08;
   localparam logic [5:0] OFS_STATUS  = 6'h0C;
   // ---------------------------------------------------------------
   // Field positions and reset values
   // ---------------------------------------------------------------
   localparam int         CMD_RW_BIT   = 7;
   localparam int         CMD_OP_LSB   = 3;
   localparam int         ADDR_DIR_BIT = 7;
   localparam int         STAT_BUSY    = 0;
   localparam logic [7:0] RST_BYTE     = 8'h00;
   localparam logic [3:0] RST_TRI      = 4'h0;
   // ---------------------------------------------------------------
   // Operation codes
   // ---------------------------------------------------------------
   localparam logic [3:0] OP_NONE   = 4'h0;
   localparam logic [3:0] OP_B70    = 4'h1;
   localparam logic [3:0] OP_B30    = 4'h2;
   localparam logic [3:0] OP_B74    = 4'h3;
   localparam logic [3:0] OP_B10    = 4'h4;
   localparam logic [3:0] OP_B32    = 4'h5;
   localparam logic [3:0] OP_B54    = 4'h6;
   localparam logic [3:0] OP_B76    = 4'h7;
   localparam logic [3:0] OP_TRI    = 4'hC;
   localparam logic [3:0] OP_TRIALL = 4'hD;
   // ---------------------------------------------------------------
   // Timing, reference clock divider and bus response codes
   // ---------------------------------------------------------------
   localparam int         ACC_REF_CYC  = 9;
   localparam int         FILL_REF_MAX = 1035;
   localparam int         REF_DIV_DEF  = 62;
   localparam logic [1:0] RESP_OKAY    = 2'h0;
   localparam logic [1:0] RESP_SLVERR  = 2'h2;
   // ---------------------------------------------------------------
   // Engine states
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_WAIT = 2'h1,
      ST_FILL = 2'h3
   } pdma_state_t;
endpackage : pdma_pkg

// ---- verilog/pdma_top.sv ----
// PCM data memory access engine with AXI4-Lite registers and PCM port
//
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
// Operation
// [R1] Upstream data resent every frame as idle
// [R2] Sub-slot writes keep other sub-slots intact
// [R3] Write command decodes opcode to bit mask
// [R4] Upstream data field readable by processor
// [R5] Downstream data field never written by commands
// [R6] Downstream read returns received slot data
// [R7] Read command returns full eight bits
// [R8] Upstream writes and tristate ops force upstream
// [R9] Tristate storage exists for upstream only
// [R10] Low impedance drives data, enable low
// [R11] High impedance tristates line, enable high
// [R12] Four tristate bits per slot, one enables
// [R13] Data bits 3..0 map to pairs
// [R14] Single slot tristate write and read opcode
// [R15] Tristate read puts code in low bits
// [R16] Global fill copies code to all slots
// [R17] Fill within limit, busy until done
// [R18] Idle code sent only under low impedance
// [R19] Busy flag high while operation runs
// [R20] Processor avoids register writes while busy
// [R21] Single access completes within nine cycles
// [R22] Opcode zero write changes nothing
module pdma_top #(
   parameter int SLOT_AW = 7,
   parameter int REF_DIV = pdma_pkg::REF_DIV_DEF
) (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write address
   input  wire logic [5:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [5:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // PCM port
   input  wire logic        pcm_rx_in,
   output logic             pcm_tx_out,
   output logic             pcm_tx_oe,
   output logic             pcm_drive_enable_line_n,
   output logic             pcm_frame_sync
);
   localparam int NSLOT = 1 << SLOT_AW;
   localparam int DIVW  = $clog2(REF_DIV + 1);

   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   logic [7:0]          up_mem [NSLOT];
   logic [7:0]          dn_mem [NSLOT];
   logic [3:0]          tri_mem [NSLOT];
   logic [7:0]          access_data_reg_r;
   logic [7:0]          access_address_reg_r;
   logic [7:0]          access_command_reg_r;
   pdma_pkg::pdma_state_t state_r;
   logic [3:0]          acc_cnt_r;
   logic [SLOT_AW-1:0]  fill_idx_r;
   logic [DIVW-1:0]     div_r;
   logic                ref_tick_r;

   // ---------------------------------------------------------------
   // Reference clock enable
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_r      <= '0;
         ref_tick_r <= 1'b0;
      end else if (div_r == DIVW'(REF_DIV - 1)) begin
         div_r      <= '0;
         ref_tick_r <= 1'b1;
      end else begin
         div_r      <= div_r + DIVW'(1);
         ref_tick_r <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // AXI4-Lite write channel
   // ---------------------------------------------------------------
   logic       aw_got_r;
   logic       w_got_r;
   logic [5:0] waddr_r;
   logic [7:0] wbyte_r;
   logic       wlane_r;
   logic       aw_take;
   logic       w_take;
   logic       wr_do;
   logic       aw_got_n;
   logic       w_got_n;
   logic       bvalid_n;

   assign aw_take  = s_axi_awvalid & s_axi_awready;
   assign w_take   = s_axi_wvalid & s_axi_wready;
   assign wr_do    = aw_got_r & w_got_r & ~s_axi_bvalid;
   assign aw_got_n = aw_take | (aw_got_r & ~wr_do);
   assign w_got_n  = w_take | (w_got_r & ~wr_do);
   assign bvalid_n = wr_do | (s_axi_bvalid & ~s_axi_bready);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_r      <= 1'b0;
         w_got_r       <= 1'b0;
         waddr_r       <= '0;
         wbyte_r       <= '0;
         wlane_r       <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= pdma_pkg::RESP_OKAY;
      end else begin
         aw_got_r      <= aw_got_n;
         w_got_r       <= w_got_n;
         s_axi_awready <= ~aw_got_n & ~bvalid_n;
         s_axi_wready  <= ~w_got_n & ~bvalid_n;
         s_axi_bvalid  <= bvalid_n;
         if (aw_take) begin
            waddr_r <= s_axi_awaddr;
         end
         if (w_take) begin
            wbyte_r <= s_axi_wdata[7:0];
            wlane_r <= s_axi_wstrb[0];
         end
         if (wr_do) begin
            case ({waddr_r[5:2], 2'b00})
               pdma_pkg::OFS_DATA,
               pdma_pkg::OFS_ADDRESS,
               pdma_pkg::OFS_COMMAND,
               pdma_pkg::OFS_STATUS: s_axi_bresp <= pdma_pkg::RESP_OKAY;
               default:              s_axi_bresp <= pdma_pkg::RESP_SLVERR;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // Command decode
   // ---------------------------------------------------------------
   logic               idle;
   logic               wr_data;
   logic               wr_addr;
   logic               cmd_go;
   logic               exec;
   logic [3:0]         op;
   logic               rd_cmd;
   logic [SLOT_AW-1:0] slot_a;
   logic [7:0]         mask;

   assign idle    = (state_r == pdma_pkg::ST_IDLE);
   assign wr_data = wr_do & wlane_r & idle & ({waddr_r[5:2], 2'b00} == pdma_pkg::OFS_DATA);
   assign wr_addr = wr_do & wlane_r & idle & ({waddr_r[5:2], 2'b00} == pdma_pkg::OFS_ADDRESS);
   assign cmd_go  = wr_do & wlane_r & idle & ({waddr_r[5:2], 2'b00} == pdma_pkg::OFS_COMMAND);
   assign exec    = (state_r == pdma_pkg::ST_WAIT) & ref_tick_r & (acc_cnt_r == 4'h1);
   assign op      = access_command_reg_r[pdma_pkg::CMD_OP_LSB +: 4];
   assign rd_cmd  = access_command_reg_r[pdma_pkg::CMD_RW_BIT];
   assign slot_a  = access_address_reg_r[SLOT_AW-1:0];

   always_comb begin
      case (op)
         pdma_pkg::OP_B70: mask = 8'hFF; // [R3]
         pdma_pkg::OP_B74: mask = 8'hF0; // [R2]
         pdma_pkg::OP_B30: mask = 8'h0F; // [R2]
         pdma_pkg::OP_B76: mask = 8'hC0; // [R2]
         pdma_pkg::OP_B54: mask = 8'h30; // [R2]
         pdma_pkg::OP_B32: mask = 8'h0C; // [R2]
         pdma_pkg::OP_B10: mask = 8'h03; // [R2]
         default:          mask = 8'h00; // [R22]
      endcase
   end

   // ---------------------------------------------------------------
   // Access registers
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         access_address_reg_r <= pdma_pkg::RST_BYTE;
         access_command_reg_r <= pdma_pkg::RST_BYTE;
      end else begin
         if (wr_addr) begin
            access_address_reg_r <= wbyte_r;
         end
         if (cmd_go) begin
            access_command_reg_r <= wbyte_r;
         end
      end
   end

   // Read results win over a stray processor write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         access_data_reg_r <= pdma_pkg::RST_BYTE;
      end else if (exec && rd_cmd && op == pdma_pkg::OP_TRI) begin
         access_data_reg_r <= {4'h0, tri_mem[slot_a]}; // [R15]
      end else if (exec && rd_cmd && !op[3]) begin
         if (access_address_reg_r[pdma_pkg::ADDR_DIR_BIT]) begin
            access_data_reg_r <= up_mem[slot_a]; // [R4] [R7]
         end else begin
            access_data_reg_r <= dn_mem[slot_a]; // [R6] [R7]
         end
      end else if (wr_data) begin
         access_data_reg_r <= wbyte_r;
      end
   end

   // ---------------------------------------------------------------
   // Access engine
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r    <= pdma_pkg::ST_IDLE;
         acc_cnt_r  <= '0;
         fill_idx_r <= '0;
      end else begin
         case (state_r)
            pdma_pkg::ST_IDLE: begin
               if (cmd_go) begin
                  state_r   <= pdma_pkg::ST_WAIT; // [R19]
                  acc_cnt_r <= 4'(pdma_pkg::ACC_REF_CYC);
               end
            end
            pdma_pkg::ST_WAIT: begin
               if (ref_tick_r) begin
                  acc_cnt_r <= acc_cnt_r - 4'h1;
               end
               if (exec) begin
                  if (!rd_cmd && op == pdma_pkg::OP_TRIALL) begin
                     state_r    <= pdma_pkg::ST_FILL; // [R17]
                     fill_idx_r <= '0;
                  end else begin
                     state_r <= pdma_pkg::ST_IDLE; // [R21]
                  end
               end
            end
            pdma_pkg::ST_FILL: begin
               fill_idx_r <= fill_idx_r + SLOT_AW'(1);
               if (fill_idx_r == SLOT_AW'(NSLOT - 1)) begin
                  state_r <= pdma_pkg::ST_IDLE; // [R17]
               end
            end
            default: state_r <= pdma_pkg::ST_IDLE;
         endcase
      end
   end

   // Upstream data field, address direction ignored
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < NSLOT; i++) begin
            up_mem[i] <= pdma_pkg::RST_BYTE;
         end
      end else if (exec && !rd_cmd && !op[3]) begin
         up_mem[slot_a] <= (up_mem[slot_a] & ~mask) | (access_data_reg_r & mask); // [R2] [R8]
      end
   end

   // Upstream tristate field only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < NSLOT; i++) begin
            tri_mem[i] <= pdma_pkg::RST_TRI; // [R9]
         end
      end else if (state_r == pdma_pkg::ST_FILL) begin
         tri_mem[fill_idx_r] <= access_data_reg_r[3:0]; // [R16]
      end else if (exec && !rd_cmd && op == pdma_pkg::OP_TRI) begin
         tri_mem[slot_a] <= access_data_reg_r[3:0]; // [R14] [R8] [R13]
      end
   end

   // ---------------------------------------------------------------
   // AXI4-Lite read channel
   // ---------------------------------------------------------------
   logic ar_take;
   logic rvalid_n;

   assign ar_take  = s_axi_arvalid & s_axi_arready;
   assign rvalid_n = ar_take | (s_axi_rvalid & ~s_axi_rready);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= pdma_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= ~rvalid_n;
         s_axi_rvalid  <= rvalid_n;
         if (ar_take) begin
            s_axi_rresp <= pdma_pkg::RESP_OKAY;
            case ({s_axi_araddr[5:2], 2'b00})
               pdma_pkg::OFS_DATA:    s_axi_rdata <= {24'h0, access_data_reg_r};
               pdma_pkg::OFS_ADDRESS: s_axi_rdata <= {24'h0, access_address_reg_r};
               pdma_pkg::OFS_COMMAND: s_axi_rdata <= {24'h0, access_command_reg_r};
               pdma_pkg::OFS_STATUS:  s_axi_rdata <= {31'h0, ~idle}; // [R19]
               default: begin
                  s_axi_rdata <= '0;
                  s_axi_rresp <= pdma_pkg::RESP_SLVERR;
               end
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // PCM frame timing
   // ---------------------------------------------------------------
   logic [SLOT_AW-1:0] tx_slot_r;
   logic [2:0]         tx_bit_r;
   logic               drive_on;

   assign drive_on = tri_mem[tx_slot_r][tx_bit_r[2:1]]; // [R12] [R13]

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_slot_r <= '0;
         tx_bit_r  <= 3'h7;
      end else if (ref_tick_r) begin
         tx_bit_r <= tx_bit_r - 3'h1;
         if (tx_bit_r == 3'h0) begin
            tx_slot_r <= tx_slot_r + SLOT_AW'(1);
         end
      end
   end

   // ---------------------------------------------------------------
   // PCM transmit
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pcm_tx_out              <= 1'b0;
         pcm_tx_oe               <= 1'b0;
         pcm_drive_enable_line_n <= 1'b1;
         pcm_frame_sync          <= 1'b0;
      end else if (ref_tick_r) begin
         pcm_tx_out              <= up_mem[tx_slot_r][tx_bit_r]; // [R1]
         pcm_tx_oe               <= drive_on; // [R10] [R11] [R18]
         pcm_drive_enable_line_n <= ~drive_on; // [R10] [R11]
         pcm_frame_sync          <= (tx_slot_r == '0) && (tx_bit_r == 3'h7);
      end
   end

   // ---------------------------------------------------------------
   // PCM receive
   // ---------------------------------------------------------------
   logic       rx_s1_r;
   logic       rx_s2_r;
   logic       rx_s3_r;
   logic       rx_val_r;
   logic [6:0] rx_sh_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_s1_r  <= 1'b0;
         rx_s2_r  <= 1'b0;
         rx_s3_r  <= 1'b0;
         rx_val_r <= 1'b0;
      end else begin
         rx_s1_r <= pcm_rx_in;
         rx_s2_r <= rx_s1_r;
         rx_s3_r <= rx_s2_r;
         if (rx_s2_r == rx_s3_r) begin
            rx_val_r <= rx_s3_r;
         end
      end
   end

   // Downstream field written by the receiver alone
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_sh_r <= '0;
         for (int i = 0; i < NSLOT; i++) begin
            dn_mem[i] <= pdma_pkg::RST_BYTE;
         end
      end else if (ref_tick_r) begin
         rx_sh_r <= {rx_sh_r[5:0], rx_val_r};
         if (tx_bit_r == 3'h0) begin
            dn_mem[tx_slot_r] <= {rx_sh_r, rx_val_r}; // [R5] [R6]
         end
      end
   end

endmodule : pdma_top
